// *** inc/comparator_control_pkg.sv ***
// constants for the comparator configuration register bank
// assumes a 32-bit apb master on pclk and an analog comparator/ladder outside
// How it works
// - bit 7 picks pin or temperature sensor
// - bit 6 enables reference, drives negative input
// - large package: 4-bit code in 5:2
// - small package: 6-bit code in 5:0
// - large package ignores bits 1:0 for level
// - reset value 0x14, 1.0 V default
// - comparator level kept apart from converter reference
// - one 8-bit rw register at f90, read back
// - result raises interrupt and reaches a pin
package comparator_control_pkg;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 12'hf90;
	localparam logic [ADDR_W-1:0] ROUTE_OFFSET  = 12'hf94;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'hf98;
	localparam logic [ADDR_W-1:0] MASK_OFFSET   = 12'hf9c;
	localparam logic [7:0] CTRL_RESET = 8'h14;
	localparam int unsigned POS_SEL_BIT = 7;
	localparam int unsigned NEG_SEL_BIT = 6;
	localparam int unsigned LEVEL_HI    = 5;
	localparam int unsigned LEVEL_LO4   = 2;
	localparam logic [3:0] LEVEL4_MAX = 4'h9;
	localparam logic [5:0] LEVEL6_MAX = 6'h24;
	localparam int unsigned EVENT_W   = 3;
	localparam int unsigned EV_RISE   = 0;
	localparam int unsigned EV_FALL   = 1;
	localparam int unsigned EV_BADLVL = 2;
	localparam int unsigned ROUTE_PIN_BIT = 0;
	localparam int unsigned ROUTE_INV_BIT = 1;
	localparam logic [1:0] ROUTE_RESET = 2'h0;
	localparam logic [EVENT_W-1:0] STATUS_RESET = 3'h0;
	localparam logic [EVENT_W-1:0] MASK_RESET   = 3'h0;
endpackage

// *** rtl/comparator_control.sv ***
// apb slave holding the comparator configuration and its event flags
// assumes comparator_raw and small_package arrive asynchronously from pins
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
module comparator_control
	import comparator_control_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              small_package,
	input  wire logic              comparator_raw,
	output logic                   positive_input_select,
	output logic                   negative_input_select,
	output logic                   reference_enable,
	output logic      [5:0]        reference_level_code,
	output logic                   comparator_pin_out,
	output logic                   comparator_pin_oe,
	output logic                   irq
);

	// effective ladder code; large package pads the two reserved lsbs with zero
	function automatic logic [5:0] level_of(input logic [7:0] val, input logic is_small);
		if (is_small)
			level_of = val[LEVEL_HI:0];
		else
			level_of = {val[LEVEL_HI:LEVEL_LO4], 2'b00};
	endfunction

	function automatic logic level_reserved(input logic [7:0] val, input logic is_small);
		if (is_small)
			level_reserved = val[LEVEL_HI:0] > LEVEL6_MAX;
		else
			level_reserved = val[LEVEL_HI:LEVEL_LO4] > LEVEL4_MAX;
	endfunction

	logic [7:0]         comparator_control;
	logic [1:0]         route;
	logic [EVENT_W-1:0] status;
	logic [EVENT_W-1:0] mask;
	logic               small_meta;
	logic               small_q;
	logic               raw_meta;
	logic               raw_q;
	logic               raw_prev;
	logic [2:0]         raw_fill;
	logic               read_error;
	logic [DATA_W-1:0]  next_prdata;
	logic [EVENT_W-1:0] next_status;

	// decode
	wire setup      = psel & ~penable;
	wire access     = psel & penable;
	wire hit_ctrl   = (paddr == CTRL_OFFSET);
	wire hit_route  = (paddr == ROUTE_OFFSET);
	wire hit_status = (paddr == STATUS_OFFSET);
	wire hit_mask   = (paddr == MASK_OFFSET);
	wire hit_any    = hit_ctrl | hit_route | hit_status | hit_mask;
	wire wr_access  = access & pwrite & hit_any;
	wire wr_ctrl    = wr_access & hit_ctrl;
	wire wr_route   = wr_access & hit_route;
	wire wr_status  = wr_access & hit_status;
	wire wr_mask    = wr_access & hit_mask;

	// events; a result already high at reset must not look like a fresh edge
	wire raw_primed = raw_fill[2];
	wire rise_event = raw_primed & raw_q & ~raw_prev;
	wire fall_event = raw_primed & ~raw_q & raw_prev;
	wire bad_level  = wr_ctrl & level_reserved(pwdata[7:0], small_q);
	wire [EVENT_W-1:0] set_bits = {bad_level, fall_event, rise_event};
	wire [EVENT_W-1:0] clr_bits = wr_status ? pwdata[EVENT_W-1:0] : '0;

	// a set in the same cycle as its clear survives
	assign next_status = (status & ~clr_bits) | set_bits;

	// read data is built in the setup cycle, so zero wait states suffice
	function automatic logic [DATA_W-1:0] read_mux(
		input logic [ADDR_W-1:0]  addr,
		input logic [7:0]         ctrl_v,
		input logic [1:0]         route_v,
		input logic [EVENT_W-1:0] status_v,
		input logic [EVENT_W-1:0] mask_v
	);
		read_mux = '0;
		if (addr == CTRL_OFFSET)
			read_mux = {24'h0, ctrl_v};
		else if (addr == ROUTE_OFFSET)
			read_mux = {30'h0, route_v};
		else if (addr == STATUS_OFFSET)
			read_mux = {29'h0, status_v};
		else if (addr == MASK_OFFSET)
			read_mux = {29'h0, mask_v};
	endfunction

	assign next_prdata = read_mux(paddr, comparator_control, route, status, mask);

	assign pready  = 1'b1;
	assign pslverr = access & read_error;

	// configuration outputs are static levels straight from the register
	assign positive_input_select = comparator_control[POS_SEL_BIT];
	assign negative_input_select = comparator_control[NEG_SEL_BIT];
	assign reference_enable      = comparator_control[NEG_SEL_BIT];
	// private ladder code; no path to the converter reference exists here
	assign reference_level_code  = level_of(comparator_control, small_q);
	assign irq                   = |(status & mask);
	assign comparator_pin_oe     = route[ROUTE_PIN_BIT];

	// package strap and comparator result come from pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			small_meta <= 1'b0;
			small_q    <= 1'b0;
			raw_meta   <= 1'b0;
			raw_q      <= 1'b0;
			raw_prev   <= 1'b0;
			raw_fill   <= 3'h0;
		end else begin
			small_meta <= small_package;
			small_q    <= small_meta;
			raw_meta   <= comparator_raw;
			raw_q      <= raw_meta;
			raw_prev   <= raw_q;
			raw_fill   <= {raw_fill[1:0], 1'b1};
		end
	end

	// write lands on the edge that completes the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			comparator_control <= CTRL_RESET;
		else if (wr_ctrl)
			comparator_control <= pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			route <= ROUTE_RESET;
			mask  <= MASK_RESET;
		end else begin
			if (wr_route)
				route <= pwdata[1:0];
			if (wr_mask)
				mask <= pwdata[EVENT_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			status <= STATUS_RESET;
		else
			status <= next_status;
	end

	// pin copy is registered; the invert lets an active-low board net work
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			comparator_pin_out <= 1'b0;
		else
			comparator_pin_out <= raw_q ^ route[ROUTE_INV_BIT];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata     <= '0;
			read_error <= 1'b0;
		end else if (setup) begin
			prdata     <= pwrite ? '0 : next_prdata;
			read_error <= ~hit_any;
		end
	end

	// assertion helpers
	logic seen_clock;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			seen_clock <= 1'b0;
		else
			seen_clock <= 1'b1;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	reset_value_a: assert property (!seen_clock |-> comparator_control == CTRL_RESET &&
		reference_level_code == CTRL_RESET[LEVEL_HI:0] && !positive_input_select)
		else $error("control not at reset value after reset");

	pos_select_a: assert property (wr_ctrl |=> positive_input_select == $past(pwdata[7]))
		else $error("positive select does not follow write");

	neg_select_a: assert property (wr_ctrl |=>
		negative_input_select == $past(pwdata[6]) && reference_enable == $past(pwdata[6]))
		else $error("negative select or reference enable wrong");

	large_level_a: assert property (wr_ctrl && !small_q |=>
		reference_level_code == {$past(pwdata[5:2]), 2'b00})
		else $error("large package level code wrong");

	small_level_a: assert property (wr_ctrl && small_q |=>
		reference_level_code == $past(pwdata[5:0]))
		else $error("small package level code wrong");

	reserved_lsb_a: assert property (!small_q |-> reference_level_code[1:0] == 2'b00)
		else $error("reserved bits reached the ladder");

	level_hold_a: assert property (!wr_ctrl ##1 $stable(small_q) |->
		$stable(reference_level_code) && $stable(positive_input_select))
		else $error("ladder code changed without a write");

	readback_a: assert property (setup && !pwrite && hit_ctrl |=>
		prdata == {24'h0, $past(comparator_control)} && !pslverr)
		else $error("control read back wrong");

	bad_level_a: assert property (bad_level |=> status[EV_BADLVL])
		else $error("reserved level write not flagged");

	edge_event_a: assert property (raw_primed && raw_q && !raw_prev |=> status[EV_RISE] ##1
		status[EV_RISE] || $past(wr_status && pwdata[EV_RISE]))
		else $error("rising result not latched");

	irq_level_a: assert property (status[EV_FALL] && mask[EV_FALL] |-> irq)
		else $error("unmasked event without interrupt");

	pin_follow_a: assert property ($changed(raw_q) && !route[ROUTE_INV_BIT]
		&& !wr_route |=> comparator_pin_out == $past(raw_q))
		else $error("pin output does not follow result");

	unmapped_a: assert property (setup && !hit_any ##1 access |->
		pslverr && prdata == '0)
		else $error("unmapped access not refused");

	status_keep_a: assert property (status[EV_RISE] &&
		!(wr_status && pwdata[EV_RISE]) |=> status[EV_RISE])
		else $error("rise flag lost without a clear");

	status_clear_a: assert property (wr_status && pwdata[EV_FALL] && !fall_event |=>
		!status[EV_FALL])
		else $error("fall flag not cleared by a written one");

	set_wins_a: assert property (wr_status && pwdata[EV_RISE] && rise_event |=>
		status[EV_RISE])
		else $error("clear beat a simultaneous rise event");

	primed_gate_a: assert property (!raw_primed && !status[EV_RISE] |=>
		!status[EV_RISE])
		else $error("rise flagged before the sync chain filled");

	irq_masked_a: assert property (mask == '0 |-> !irq)
		else $error("interrupt raised with every event masked");

	mask_write_a: assert property (wr_mask |=> mask == $past(pwdata[EVENT_W-1:0]))
		else $error("mask does not follow write");

	route_write_a: assert property (wr_route |=>
		comparator_pin_oe == $past(pwdata[ROUTE_PIN_BIT]))
		else $error("pin enable does not follow write");

	pin_invert_a: assert property ($changed(raw_q) && route[ROUTE_INV_BIT]
		&& !wr_route |=> comparator_pin_out == !$past(raw_q))
		else $error("inverted pin output wrong");

	status_read_a: assert property (setup && !pwrite && hit_status |=>
		prdata == {29'h0, $past(status)})
		else $error("status read back wrong");

	lsb_store_a: assert property (wr_ctrl |=>
		comparator_control[1:0] == $past(pwdata[1:0]))
		else $error("low control bits not stored");

	write_refused_a: assert property (access && pwrite && !hit_any |=>
		$stable(comparator_control) && $stable(route) && $stable(mask))
		else $error("unmapped write changed a register");

	large_reserved_a: assert property (wr_ctrl && !small_q &&
		pwdata[LEVEL_HI:LEVEL_LO4] > LEVEL4_MAX |=> status[EV_BADLVL])
		else $error("reserved large code not flagged");

	small_reserved_a: assert property (wr_ctrl && small_q &&
		pwdata[LEVEL_HI:0] > LEVEL6_MAX |=> status[EV_BADLVL])
		else $error("reserved small code not flagged");

	legal_level_a: assert property (wr_ctrl && !small_q && !status[EV_BADLVL] &&
		pwdata[LEVEL_HI:LEVEL_LO4] <= LEVEL4_MAX |=> !status[EV_BADLVL])
		else $error("legal level code flagged as reserved");

	idle_outputs_a: assert property (!seen_clock |-> !irq && !comparator_pin_oe &&
		!comparator_pin_out && !pslverr)
		else $error("outputs not idle after reset");

	write_ctrl_c: cover property (wr_ctrl ##1 reference_enable);
	small_write_c: cover property (small_q && wr_ctrl);
	irq_rise_c: cover property (!irq ##1 irq);
	clear_race_c: cover property (wr_status && rise_event && pwdata[EV_RISE]);
	small_bad_c: cover property (small_q && bad_level);

endmodule // comparator_control

// *** verification/comparator_control_tb.sv ***
// self-checking bench for the comparator configuration bank
// assumes zero-wait apb slave and the behavioural comparator model
`timescale 1ns/1ps
module comparator_control_tb;
	import comparator_control_pkg::*;
	logic              pclk, presetn, psel, penable, pwrite, small_package, e;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, r;
	logic              pready, pslverr, raw, pos_sel, neg_sel, ref_en, pin_out, pin_oe, irq;
	logic [5:0]        level;
	int                errors, checks_done, pin_p_mv, pin_n_mv;
	int                sent_q[$];
	comparator_control dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .small_package(small_package), .comparator_raw(raw),
		.positive_input_select(pos_sel), .negative_input_select(neg_sel),
		.reference_enable(ref_en), .reference_level_code(level),
		.comparator_pin_out(pin_out), .comparator_pin_oe(pin_oe), .irq(irq));
	comparator_far_end far_u (.positive_input_select(pos_sel), .negative_input_select(neg_sel),
		.reference_enable(ref_en), .small_package(small_package),
		.reference_level_code(level), .pin_p_mv(pin_p_mv), .pin_n_mv(pin_n_mv),
		.comparator_raw(raw));
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
			$display("ERROR t=%0t pready got=%h exp=%h", $time, pready, 1'b1);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		apb(1'b0, a, '0);
		chk(r, exp);
	endtask
	task automatic cfg(input logic [7:0] c);
		int lv;
		int bad;
		// ladder code and reserved flag reckoned in integers
		lv = small_package ? c % 64 : (c / 4 % 16) * 4;
		bad = small_package ? int'(lv > LEVEL6_MAX) : int'(c / 4 % 16 > LEVEL4_MAX);
		sent_q.push_back(int'(c));
		apb(1'b1, CTRL_OFFSET, {24'h0, c});
		chk(32'({pos_sel, neg_sel, ref_en, level}), 32'({c[7], c[6], c[6], 6'(lv)}));
		rd(CTRL_OFFSET, 32'(sent_q.pop_front()));
		apb(1'b0, STATUS_OFFSET, '0);
		chk(32'(r[2]), 32'(bad));
		apb(1'b1, STATUS_OFFSET, 32'h7);
	endtask
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	initial begin
		#(3000 * 50);
		errors++;
		$display("ERROR t=%0t watchdog expired", $time);
		give_verdict;
	end
	initial begin
		{psel, penable, pwrite, presetn, small_package} = '0;
		paddr = '0;
		pwdata = '0;
		pin_p_mv = 500;
		pin_n_mv = 1000;
		void'($urandom(54037));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(CTRL_OFFSET, 32'(CTRL_RESET));
		rd(ROUTE_OFFSET, '0);
		rd(STATUS_OFFSET, '0);
		rd(MASK_OFFSET, '0);
		chk(32'({pos_sel, neg_sel, ref_en, level, irq}), 32'({3'b000, CTRL_RESET[5:0], 1'b0}));
		$display("test reset done");
		cfg(8'h24);
		cfg(8'h28);
		cfg(8'hfd);
		repeat (6) cfg(8'($urandom));
		$display("test large package done");
		apb(1'b1, 12'hfa0, 32'hff);
		chk(32'(e), 32'h1);
		apb(1'b0, 12'hfa0, '0);
		chk(32'({e, r[30:0]}), 32'h80000000);
		$display("test unmapped done");
		apb(1'b1, MASK_OFFSET, 32'h0);
		cfg(8'h14);
		repeat (6) @(posedge pclk);
		apb(1'b1, STATUS_OFFSET, 32'h7);
		apb(1'b1, MASK_OFFSET, 32'h1);
		apb(1'b1, ROUTE_OFFSET, 32'h3);
		pin_p_mv <= 1500;
		repeat (6) @(posedge pclk);
		chk(32'({irq, pin_oe, pin_out}), 32'h6);
		rd(STATUS_OFFSET, 32'h1);
		apb(1'b1, MASK_OFFSET, 32'h0);
		chk(32'(irq), 32'h0);
		pin_p_mv <= 500;
		repeat (6) @(posedge pclk);
		rd(STATUS_OFFSET, 32'h3);
		apb(1'b1, STATUS_OFFSET, 32'h3);
		rd(STATUS_OFFSET, 32'h0);
		apb(1'b1, ROUTE_OFFSET, 32'h1);
		pin_p_mv <= 1200;
		pin_n_mv <= 2000;
		apb(1'b1, CTRL_OFFSET, 32'h54);
		repeat (6) @(posedge pclk);
		chk(32'(pin_out), 32'h1);
		$display("test events done");
		presetn <= 1'b0;
		small_package <= 1'b1;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		rd(CTRL_OFFSET, 32'(CTRL_RESET));
		cfg(8'h24);
		cfg(8'h25);
		cfg(8'h03);
		repeat (6) cfg(8'($urandom));
		$display("test small package done");
		give_verdict;
	end
endmodule // comparator_control_tb

// *** verification/comparator_far_end.sv ***
// behavioural comparator with its input muxes and reference ladder
// assumes pin voltages in millivolts come from the bench
`timescale 1ns/1ps
module comparator_far_end (
	input  wire logic       positive_input_select,
	input  wire logic       negative_input_select,
	input  wire logic       reference_enable,
	input  wire logic       small_package,
	input  wire logic [5:0] reference_level_code,
	input  int              pin_p_mv,
	input  int              pin_n_mv,
	output logic            comparator_raw
);
	localparam int SENSOR_MV = 900;
	int ref_mv;
	int pos_mv;
	int neg_mv;
	always_comb begin
		ref_mv = small_package ? reference_level_code * 50 : (reference_level_code >> 2) * 200;
		pos_mv = positive_input_select ? SENSOR_MV : pin_p_mv;
		neg_mv = (negative_input_select && reference_enable) ? ref_mv : pin_n_mv;
		// no hysteresis: ties read as low
		comparator_raw = pos_mv > neg_mv;
	end
endmodule // comparator_far_end
